// File: hw/rsq_sequencer.sv
// reset and start-up sequencer: cause tracking, pin filter, start-up timers
`timescale 1ns/1ps

// Behaviour
// RL1: six reset causes told apart and recorded
// RL2: non-wake causes pulse the register initialise line
// RL3: scratch group never reset by any cause
// RL4: watchdog wake leaves register initialise low
// RL5: expired and sleep flags follow the cause
// RL6: short low pulses on reset pin ignored
// RL7: watchdog reset acts internally, pin untouched
// RL8: supply rise makes an internal power-on pulse
// RL9: power-up timer starts from power-on pulse
// RL10: core held in reset while timer counts
// RL11: power-up timer counts internal rc edges
// RL12: configuration bit enables or skips power-up timer
// RL13: start-up timer holds 1024 oscillator cycles
// RL14: start-up timer only in crystal modes
// RL15: start-up timer only after power-on or wake
// RL16: oscillator pin may carry an external clock
// RL17: power-on flag cleared only by power-on
// RL18: power-up delay follows supply above dip level
// RL19: power-up enable bit is active low
// RL20: supply dip enable forces power-up timer on
// RL21: core reset held until last timer ends
// RL22: start-up counter restarts, counts rising edges
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int RC_FREQ_KHZ = RC_FREQ_KHZ_DEF,
    parameter int PUT_TICKS   = PUT_TIME_MS * RC_FREQ_KHZ
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    // pins and analog detectors
    input  wire logic              external_reset_pin_n,
    input  wire logic              oscillator_input_pin,
    input  wire logic              rc_osc_in,
    input  wire logic              supply_ok,
    input  wire logic              supply_below_dip,
    // core side
    input  wire logic              watchdog_timeout,
    input  wire logic              core_sleeping,
    output logic                   core_reset,
    output logic                   regs_init,
    output logic                   wake_resume
);

    localparam int PUT_W = $clog2(PUT_TICKS + 1);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (PUT_TICKS < 1) begin : g_bad_put
        $error("power-up tick count must be at least one");
    end
    if (RC_FREQ_KHZ < 1) begin : g_bad_rc
        $error("rc rate must be at least one kHz");
    end

    // ************************************************************
    // state
    // ************************************************************
    rsq_state_e          state_reg, state_next;
    rsq_cause_e          cause_reg, cause_next;
    rsq_cfg_s            cfg_reg, cfg_next;
    rsq_status_s         status_reg, status_next;
    logic [DATA_W-1:0]   scratch_reg;
    logic [DATA_W-1:0]   rd_data_reg, rd_data_next;
    logic                supply_ok_d_reg;
    logic                pin_filt_reg, pin_filt_next;
    logic [FILT_W-1:0]   filt_cnt_reg, filt_cnt_next;
    logic                osc_d_reg;
    logic                rc_d_reg;
    logic [PUT_W-1:0]    put_cnt_reg, put_cnt_next;
    logic [OST_W-1:0]    ost_cnt_reg, ost_cnt_next;
    logic                core_reset_reg;
    logic                regs_init_reg;
    logic                wake_resume_reg, wake_resume_next;

    // ************************************************************
    // event decode
    // ************************************************************
    wire por_pulse  = supply_ok & ~supply_ok_d_reg;                       // [RL8]
    wire dip_act    = cfg_reg.supply_dip_reset_enable & supply_below_dip;
    wire pin_low    = ~pin_filt_reg;
    wire in_run     = (state_reg == ST_RUN);
    wire wdt_reset  = in_run & watchdog_timeout & ~core_sleeping;         // [RL7]
    wire wdt_wake   = in_run & watchdog_timeout & core_sleeping;
    wire osc_edge   = oscillator_input_pin & ~osc_d_reg;                 // [RL22] [RL16]
    wire rc_edge    = rc_osc_in & ~rc_d_reg;                             // [RL11]
    wire crystal    = (cfg_reg.osc_mode != OSC_RESISTOR_CAP);            // [RL14]
    wire put_on     = ~cfg_reg.power_up_delay_enable_n                   // [RL19] [RL12]
                    | cfg_reg.supply_dip_reset_enable;                   // [RL20]
    wire put_done   = rc_edge & (put_cnt_reg == PUT_W'(PUT_TICKS - 1));
    wire ost_done   = osc_edge & (ost_cnt_reg == OST_W'(OST_EDGES - 1)); // [RL13]
    wire pin_change = (external_reset_pin_n != pin_filt_reg);

    // power-up delay after power-on or dip, or after any reset when dip reset is on
    function automatic logic put_needed(input rsq_cause_e c, input logic on, input logic dip_en);
        put_needed = on & ((c == CAUSE_POWER_ON) | (c == CAUSE_SUPPLY_DIP) | dip_en);
    endfunction

    // start-up delay only after power-on or wake, and only with a crystal
    function automatic logic ost_needed(input rsq_cause_e c, input logic xtal);
        ost_needed = xtal & ((c == CAUSE_POWER_ON) | (c == CAUSE_WDT_WAKE)); // [RL15]
    endfunction

    // a cause newly seen while running, highest priority first
    function automatic rsq_cause_e new_cause(input logic por, input logic dip,
                                            input logic pinl, input logic sleeping,
                                            input logic wrst, input logic wwake);
        if (por) begin
            new_cause = CAUSE_POWER_ON;
        end else if (dip) begin
            new_cause = CAUSE_SUPPLY_DIP;
        end else if (pinl) begin
            new_cause = sleeping ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
        end else if (wrst) begin
            new_cause = CAUSE_WDT_RESET;
        end else if (wwake) begin
            new_cause = CAUSE_WDT_WAKE;
        end else begin
            new_cause = CAUSE_NONE;
        end
    endfunction

    wire rsq_cause_e seen_cause = new_cause(por_pulse, dip_act, pin_low, core_sleeping,
                                            wdt_reset, wdt_wake);   // [RL1]
    wire cause_load = por_pulse | (in_run & (seen_cause != CAUSE_NONE));

    // ************************************************************
    // pin noise filter: level must hold for the filter time to be taken
    // ************************************************************
    always_comb begin
        filt_cnt_next = '0;
        pin_filt_next = pin_filt_reg;
        if (pin_change) begin
            if (filt_cnt_reg == FILT_W'(PIN_FILTER_CYC - 1)) begin
                pin_filt_next = external_reset_pin_n;                     // [RL6]
            end else begin
                filt_cnt_next = filt_cnt_reg + FILT_W'(1);
            end
        end
    end

    // ************************************************************
    // sequence state machine
    // ************************************************************
    always_comb begin
        state_next       = state_reg;
        cause_next       = cause_reg;
        put_cnt_next     = put_cnt_reg;
        ost_cnt_next     = ost_cnt_reg;
        wake_resume_next = 1'b0;
        if (put_on & rc_edge) begin
            put_cnt_next = put_cnt_reg + PUT_W'(1);
        end
        if (osc_edge) begin
            ost_cnt_next = ost_cnt_reg + OST_W'(1);
        end
        unique case (state_reg)
            ST_RUN: begin
                if (cause_load & (seen_cause == CAUSE_WDT_WAKE)) begin
                    cause_next   = CAUSE_WDT_WAKE;                        // [RL4]
                    ost_cnt_next = '0;
                    if (crystal) begin
                        state_next = ST_OST;
                    end else begin
                        wake_resume_next = 1'b1;
                    end
                end else if (cause_load) begin
                    cause_next = seen_cause;
                    state_next = ST_HOLD;                                 // [RL21]
                end
            end
            ST_HOLD: begin
                put_cnt_next = '0;
                ost_cnt_next = '0;                                        // [RL22]
                if (supply_ok & ~dip_act) begin                           // [RL18]
                    if (put_needed(cause_reg, put_on, cfg_reg.supply_dip_reset_enable)) begin
                        state_next = ST_PUT;                              // [RL9]
                    end else if (ost_needed(cause_reg, crystal)) begin
                        state_next = ST_OST;
                    end else begin
                        state_next = ST_PIN;
                    end
                end
            end
            ST_PUT: begin
                if (put_done) begin
                    ost_cnt_next = '0;
                    state_next   = ost_needed(cause_reg, crystal) ? ST_OST : ST_PIN;
                end
            end
            ST_OST: begin
                if (ost_done) begin
                    state_next = ST_PIN;
                end
            end
            ST_PIN: begin
                if (~pin_low) begin
                    state_next       = ST_RUN;
                    wake_resume_next = (cause_reg == CAUSE_WDT_WAKE);
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        // a power-on pulse or a dip restarts the sequence from any state
        if (state_reg != ST_RUN) begin
            if (por_pulse) begin
                cause_next = CAUSE_POWER_ON;
                state_next = ST_HOLD;
            end else if (dip_act) begin
                state_next = ST_HOLD;
            end
        end
        // a wake headed for the start-up timer outside a crystal mode goes straight to the pin check
        if ((state_next == ST_OST) & ~crystal & (cause_next == CAUSE_WDT_WAKE)) begin
            state_next = ST_PIN;
        end
    end

    // ************************************************************
    // cause flags: hardware update wins over a software write
    // ************************************************************
    wire sw_stat_wr = wr_en & (addr == ADDR_STATUS);

    always_comb begin
        status_next = status_reg;
        if (sw_stat_wr) begin
            status_next.supply_dip_flag = status_reg.supply_dip_flag | wr_data[STAT_DIP_BIT];
            status_next.power_on_flag   = status_reg.power_on_flag | wr_data[STAT_PON_BIT];
        end
        if (cause_load) begin                                             // [RL5]
            unique case (seen_cause)
                CAUSE_POWER_ON: begin
                    status_next.power_on_flag = 1'b0;                     // [RL17]
                    if (cfg_reg.supply_dip_reset_enable) begin
                        status_next.supply_dip_flag = 1'b1;
                    end
                    status_next.watchdog_expired_flag_n = 1'b1;
                    status_next.sleep_entered_flag_n    = 1'b1;
                end
                CAUSE_SUPPLY_DIP: begin
                    status_next.supply_dip_flag         = 1'b0;
                    status_next.watchdog_expired_flag_n = 1'b1;
                    status_next.sleep_entered_flag_n    = 1'b1;
                end
                CAUSE_PIN_SLEEP: begin
                    status_next.watchdog_expired_flag_n = 1'b1;
                    status_next.sleep_entered_flag_n    = 1'b0;
                end
                CAUSE_WDT_RESET: begin
                    status_next.watchdog_expired_flag_n = 1'b0;
                    status_next.sleep_entered_flag_n    = 1'b1;
                end
                CAUSE_WDT_WAKE: begin
                    status_next.watchdog_expired_flag_n = 1'b0;
                    status_next.sleep_entered_flag_n    = 1'b0;
                end
                default: begin
                    status_next = status_next;                            // pin while running
                end
            endcase
        end
    end

    // ************************************************************
    // register port decode
    // ************************************************************
    wire cfg_wr = wr_en & (addr == ADDR_CFG);
    assign cfg_next = cfg_wr ? rsq_cfg_s'(wr_data[3:0]) : cfg_reg;

    always_comb begin
        rd_data_next = '0;
        if (rd_en) begin
            unique case (addr)
                ADDR_CFG:     rd_data_next = {4'h0, cfg_reg};
                ADDR_STATUS:  rd_data_next = {4'h0, status_reg};
                ADDR_CAUSE:   rd_data_next = {2'h0, state_reg, cause_reg};
                ADDR_SCRATCH: rd_data_next = scratch_reg;
                default:      rd_data_next = '0;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // sequence and filter state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg       <= ST_HOLD;
            cause_reg       <= CAUSE_POWER_ON;
            supply_ok_d_reg <= 1'b0;
            pin_filt_reg    <= 1'b1;
            filt_cnt_reg    <= '0;
            osc_d_reg       <= 1'b0;
            rc_d_reg        <= 1'b0;
            put_cnt_reg     <= '0;
            ost_cnt_reg     <= '0;
        end else begin
            state_reg       <= state_next;
            cause_reg       <= cause_next;
            supply_ok_d_reg <= supply_ok;
            pin_filt_reg    <= pin_filt_next;
            filt_cnt_reg    <= filt_cnt_next;
            osc_d_reg       <= oscillator_input_pin;
            rc_d_reg        <= rc_osc_in;
            put_cnt_reg     <= put_cnt_next;
            ost_cnt_reg     <= ost_cnt_next;
        end
    end

    // software visible registers and outputs
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg         <= CFG_RESET;
            status_reg      <= STATUS_RESET;
            rd_data_reg     <= '0;
            core_reset_reg  <= 1'b1;
            regs_init_reg   <= 1'b1;
            wake_resume_reg <= 1'b0;
        end else begin
            cfg_reg         <= cfg_next;
            status_reg      <= status_next;
            rd_data_reg     <= rd_data_next;
            core_reset_reg  <= (state_next != ST_RUN);                    // [RL10] [RL21]
            regs_init_reg   <= (state_next != ST_RUN)                     // [RL2]
                             & (cause_next != CAUSE_WDT_WAKE);             // [RL4]
            wake_resume_reg <= wake_resume_next;
        end
    end

    // preserved group: no reset of any kind reaches it
    always_ff @(posedge mclk) begin
        if (wr_en & (addr == ADDR_SCRATCH)) begin
            scratch_reg <= wr_data;                                       // [RL3]
        end
    end

    assign rd_data     = rd_data_reg;
    assign core_reset  = core_reset_reg;
    assign regs_init   = regs_init_reg;
    assign wake_resume = wake_resume_reg;

endmodule // rsq_sequencer

// File: inc/rsq_pkg.sv
// constants, types and register map of the reset and start-up sequencer
package rsq_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 8;                  // mclk period at 125 MHz
    localparam int PIN_FILTER_NS   = 100;                // least low time of a real pin reset
    localparam int PIN_FILTER_CYC  = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUT_TIME_MS     = 72;                 // power-up timer delay
    localparam int RC_FREQ_KHZ_DEF = 1000;               // nominal internal rc rate
    localparam int OST_EDGES       = 1024;               // oscillator start-up edge count
    localparam int OST_W           = $clog2(OST_EDGES);
    localparam int FILT_W          = $clog2(PIN_FILTER_CYC + 1);

    // ************************************************************
    // register port
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CFG     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 4'h3;

    // field positions
    localparam int STAT_DIP_BIT   = 0;                   // supply dip flag, 0 after a dip
    localparam int STAT_PON_BIT   = 1;                   // power-on flag, 0 after power-on
    localparam int STAT_WDX_BIT   = 2;                   // watchdog_expired_flag, active low
    localparam int STAT_SLP_BIT   = 3;                   // sleep_entered_flag, active low

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL = 2'b00,
        OSC_STANDARD_CRYSTAL  = 2'b01,
        OSC_HIGH_SPEED_CRYSTAL= 2'b10,
        OSC_RESISTOR_CAP      = 2'b11
    } rsq_osc_mode_e;

    typedef enum logic [2:0] {
        CAUSE_NONE      = 3'b000,
        CAUSE_POWER_ON  = 3'b001,
        CAUSE_PIN_RUN   = 3'b010,
        CAUSE_PIN_SLEEP = 3'b011,
        CAUSE_WDT_RESET = 3'b100,
        CAUSE_WDT_WAKE  = 3'b101,
        CAUSE_SUPPLY_DIP= 3'b110
    } rsq_cause_e;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_HOLD = 3'b001,
        ST_PUT  = 3'b010,
        ST_OST  = 3'b011,
        ST_PIN  = 3'b100
    } rsq_state_e;

    // configuration word: bits [3:0] of the cfg register
    typedef struct packed {
        logic          supply_dip_reset_enable;   // bit 3
        logic          power_up_delay_enable_n;   // bit 2, active low
        rsq_osc_mode_e osc_mode;                  // bits 1:0
    } rsq_cfg_s;

    // reset cause flags: bits [3:0] of the status register
    typedef struct packed {
        logic sleep_entered_flag_n;
        logic watchdog_expired_flag_n;
        logic power_on_flag;
        logic supply_dip_flag;
    } rsq_status_s;

    localparam rsq_cfg_s    CFG_RESET    = '{1'b1, 1'b0, OSC_STANDARD_CRYSTAL};
    localparam rsq_status_s STATUS_RESET = '{1'b1, 1'b1, 1'b0, 1'b1};

endpackage

// File: bench/rsq_far_model.sv
// far side model: internal rc source and external clock into the oscillator pin
`timescale 1ns/1ps
module rsq_far_model (
    // clock and control
    input  wire logic mclk,
    input  wire logic osc_run,
    // clocks toward the block
    output logic      rc_osc_in,
    output logic      oscillator_input_pin
);
    logic [2:0] rc_div_reg = 3'h0;
    logic       osc_reg    = 1'b0;

    // rc source: one rising edge every 8 mclk cycles
    always @(posedge mclk) begin
        rc_div_reg <= rc_div_reg + 3'h1;
    end
    assign rc_osc_in = rc_div_reg[2];

    // external clock driven into the oscillator pin, still when stopped
    always @(posedge mclk) begin
        osc_reg <= osc_run ? ~osc_reg : 1'b0;
    end
    assign oscillator_input_pin = osc_reg;
endmodule // rsq_far_model

// File: bench/rsq_sequencer_assertions.sv
// port-level checks of the reset and start-up sequencer
`timescale 1ns/1ps
module rsq_sequencer_checker
    import rsq_pkg::*;
(
    // clock, reset and inputs
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire logic              rd_en,
    input wire logic              external_reset_pin_n,
    input wire logic              supply_ok,
    input wire logic              watchdog_timeout,
    input wire logic              core_sleeping,
    // outputs
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              core_reset,
    input wire logic              regs_init,
    input wire logic              wake_resume
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_por_core_hold: assert property ($rose(supply_ok) |=> core_reset [*2])
        else $error("core not held after supply rise");
    a_wdt_run_reset: assert property (watchdog_timeout && !core_reset && !core_sleeping
        |=> ##[0:1] (core_reset && regs_init)) else $error("watchdog reset missed");
    a_wake_no_init: assert property (watchdog_timeout && !core_reset && core_sleeping
        |=> !regs_init [*4]) else $error("wake touched registers");
    a_pin_short_ign: assert property ($fell(external_reset_pin_n) && !core_reset
        && supply_ok |=> !core_reset [*8]) else $error("short pin pulse reset core");
    a_pin_long_rst: assert property ((!external_reset_pin_n) [*8] ##1
        (!external_reset_pin_n) [*8] |-> ##[0:4] core_reset) else $error("pin reset missed");
    a_release_supply: assert property ($fell(core_reset) |-> supply_ok)
        else $error("core released without supply");
    a_release_pin: assert property ($fell(core_reset) |-> $past(external_reset_pin_n))
        else $error("core released with pin low");
    a_init_in_reset: assert property ($rose(regs_init) |-> core_reset)
        else $error("register init outside core reset");
    a_wake_pulse_one: assert property (wake_resume |-> !regs_init ##1 !wake_resume)
        else $error("wake resume not a clean pulse");
    a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == '0)
        else $error("read data outside read slot");
endmodule // rsq_sequencer_checker

bind rsq_sequencer rsq_sequencer_checker i_checker (
    .mclk(mclk), .arst_n(arst_n), .rd_en(rd_en),
    .external_reset_pin_n(external_reset_pin_n), .supply_ok(supply_ok),
    .watchdog_timeout(watchdog_timeout), .core_sleeping(core_sleeping),
    .rd_data(rd_data), .core_reset(core_reset), .regs_init(regs_init),
    .wake_resume(wake_resume)
);

// File: bench/testbench.sv
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module testbench
    import rsq_pkg::*;
;
    localparam int PUT_T  = 8;   // shortened power-up count in rc edges
    localparam int RC_CYC = 8;   // mclk cycles per rc edge in the model
    logic              mclk = 1'b0;
    logic              arst_n, wr_en, rd_en, pin_n, osc_pin, rc_in, osc_run;
    logic              supply_ok, below_dip, wdt, sleeping, core_reset, regs_init, wake_rsm;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, d;
    int                n, mismatches, total_checks;

    always #4 mclk = ~mclk;

    rsq_sequencer #(.PUT_TICKS(PUT_T)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .external_reset_pin_n(pin_n),
        .oscillator_input_pin(osc_pin), .rc_osc_in(rc_in), .supply_ok(supply_ok),
        .supply_below_dip(below_dip), .watchdog_timeout(wdt), .core_sleeping(sleeping),
        .core_reset(core_reset), .regs_init(regs_init), .wake_resume(wake_rsm));
    rsq_far_model i_far (.mclk(mclk), .osc_run(osc_run), .rc_osc_in(rc_in),
        .oscillator_input_pin(osc_pin));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask
    task automatic wait_core(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (core_reset !== lvl && cnt < max) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
    endtask
    task automatic pin_low(input int len);
        @(posedge mclk);
        pin_n <= 1'b0;
        repeat (len) @(posedge mclk);
        pin_n <= 1'b1;
        #1;
    endtask
    task automatic wdt_pulse();
        @(posedge mclk);
        wdt <= 1'b1;
        @(posedge mclk);
        wdt <= 1'b0;
    endtask
    task automatic chk_regs(input logic [7:0] st, input rsq_cause_e c);
        rd(ADDR_STATUS, d);
        chk("status", st, d);
        rd(ADDR_CAUSE, d);
        chk("cause", {5'h00, c}, d);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power_on();
        rd(ADDR_CFG, d);
        chk("cfg reset", 8'h09, d);
        @(posedge mclk);
        supply_ok <= 1'b1;
        wait_core(1'b0, 3000, n);
        chk("startup min", 8'h01, 8'(n >= 2 * OST_EDGES + RC_CYC * PUT_T));
        chk("startup max", 8'h01, 8'(n <= 2 * OST_EDGES + RC_CYC * PUT_T + 48));
        chk_regs(8'h0D, CAUSE_POWER_ON);
    endtask
    task automatic t_pin_run();
        wr(ADDR_STATUS, 8'h03);
        wr(ADDR_CFG, 8'h07);
        wr(ADDR_SCRATCH, 8'hA5);
        pin_low(12);
        repeat (4) @(posedge mclk);
        #1;
        chk("short pulse", 8'h00, {7'h00, core_reset});
        pin_low(20);
        chk("pin hold", 8'h03, {6'h00, core_reset, regs_init});
        wait_core(1'b0, 40, n);
        chk("pin release", 8'h00, {7'h00, core_reset});
        chk_regs(8'h0F, CAUSE_PIN_RUN);
        rd(ADDR_SCRATCH, d);
        chk("scratch", 8'hA5, d);
        rd(4'h7, d);
        chk("unmapped", 8'h00, d);
    endtask
    task automatic t_wdt_reset();
        wr(ADDR_CFG, 8'h04);
        wdt_pulse();
        wait_core(1'b1, 5, n);
        chk("wdt hold", 8'h03, {6'h00, core_reset, regs_init});
        wait_core(1'b0, 40, n);
        chk("wdt release", 8'h00, {7'h00, core_reset});
        chk_regs(8'h0B, CAUSE_WDT_RESET);
    endtask
    task automatic t_wdt_wake();
        logic seen;
        seen = 1'b0;
        @(posedge mclk);
        sleeping <= 1'b1;
        wdt_pulse();
        n = 0;
        while (wake_rsm !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
            seen = seen | (regs_init !== 1'b0);
        end
        chk("wake init", 8'h00, {7'h00, seen});
        chk("wake ost", 8'h01, 8'(n >= 2 * OST_EDGES - 4 && n < 3000));
        @(posedge mclk) sleeping <= 1'b0;
        chk_regs(8'h03, CAUSE_WDT_WAKE);
    endtask
    task automatic t_pin_sleep();
        @(posedge mclk);
        sleeping <= 1'b1;
        pin_low(20);
        wait_core(1'b0, 3000, n);
        @(posedge mclk) sleeping <= 1'b0;
        chk_regs(8'h07, CAUSE_PIN_SLEEP);
    endtask
    task automatic t_dip();
        wr(ADDR_CFG, 8'h0E);
        @(posedge mclk);
        below_dip <= 1'b1;
        wait_core(1'b1, 5, n);
        chk("dip hold", 8'h01, {7'h00, core_reset});
        repeat (5) @(posedge mclk);
        below_dip <= 1'b0;
        wait_core(1'b0, 400, n);
        chk("dip delay", 8'h01, 8'(n >= RC_CYC * (PUT_T - 1) && n < 400));
        chk_regs(8'h0E, CAUSE_SUPPLY_DIP);
    endtask
    task automatic t_por_fast();
        wr(ADDR_CFG, 8'h07);
        supply_ok <= 1'b0;
        @(posedge mclk);
        supply_ok <= 1'b1;
        wait_core(1'b1, 5, n);
        chk("por hold", 8'h01, {7'h00, core_reset});
        wait_core(1'b0, 40, n);
        chk("put skip", 8'h01, 8'(n < RC_CYC));
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #300000;
        mismatches++;
        end_of_test();
    end

    // main sequence
    initial begin
        {arst_n, wr_en, rd_en, osc_run, supply_ok, below_dip, wdt, sleeping} = 8'h00;
        {addr, wr_data, pin_n, mismatches, total_checks} = '0;
        pin_n = 1'b1;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        osc_run <= 1'b1;
        t_power_on();
        t_pin_run();
        t_wdt_reset();
        t_wdt_wake();
        t_pin_sleep();
        t_dip();
        t_por_fast();
        end_of_test();
    end
endmodule // testbench
